// [shared/gpio_port_defines.vh]
// Constants for the pin routing and general purpose IO block
// ============================================================
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

// ============================================================
// Register indices (byte address is four times the index)
`define IDX_CONTROL       16'hc006
`define IDX_OUT_LOW       16'hc01e
`define IDX_IN_LOW        16'hc020
`define IDX_DIR_LOW       16'hc022
`define IDX_OUT_HIGH      16'hc024
`define IDX_IN_HIGH       16'hc026
`define IDX_DIR_HIGH      16'hc028
`define IDX_IRQ_STATUS    16'hc0f0
`define IDX_IRQ_MASK      16'hc0f2

// ============================================================
// Control register fields
`define CTL_WRITE_PROTECT 15
`define CTL_TX_EXPORT     14
`define CTL_SS_REROUTE    11
`define CTL_MODE_HI       10
`define CTL_MODE_LO       8
`define CTL_FAST_EN       7
`define CTL_FAST_MEM      6
`define CTL_SPI_EN        5
`define CTL_SPI_MEM       4
`define CTL_PIN_INTERRUPT_ONE_RISE     3
`define CTL_PIN_INTERRUPT_ONE_EN       2
`define CTL_PIN_INTERRUPT_ZERO_RISE     1
`define CTL_PIN_INTERRUPT_ZERO_EN       0
`define CTL_WRITABLE      16'hcfff
`define CTL_RESET         16'h0000

// ============================================================
// Pin function codes, pin register reset value and fixed pin numbers
`define MODE_GPIO         3'h0
`define MODE_DRIVE_IF     3'h4
`define MODE_HOST_PORT    3'h5
`define MODE_SCAN         3'h6
`define PIN_REG_RESET     16'h0000
`define IRQ_PIN_ZERO      24
`define IRQ_PIN_ONE       25
`define TX_EXPORT_PIN     30
`define SS_ALT_PIN        15

// ============================================================
// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [core/pin_cell.v]
// One pin: chooses between GPIO registers and a routed peripheral
module pin_cell (
  input  wire gpio_data,
  input  wire gpio_dir,
  input  wire fn_claim,
  input  wire fn_out,
  input  wire fn_oe,
  output wire pin_out,
  output wire pin_oe
);

  // A claimed pin ignores its GPIO bits entirely
  assign pin_out = fn_claim ? fn_out : gpio_data;
  assign pin_oe  = fn_claim ? fn_oe  : gpio_dir;

endmodule

// [core/pin_edge_detect.v]
// Edge detector for one pin interrupt source
module pin_edge_detect (
  input  wire ref_clk,
  input  wire arst_n,
  input  wire level,
  input  wire rise_sel,
  input  wire enable,
  output wire event_pulse
);

  reg last_ff;

  // ============================================================
  // Previous level, reset low so a high pin at release looks like a rise
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= level;
    end
  end

  // Polarity picks which transition counts
  assign event_pulse = enable & (rise_sel ? (level & ~last_ff) : (~level & last_ff));

endmodule

// [core/gpio_port.v]
// Pin routing and general purpose IO block with AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`include "gpio_port_defines.vh"

module gpio_port (
  input  wire        ref_clk,
  input  wire        arst_n,
  // AXI4-Lite slave
  input  wire [19:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [19:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt
  input  wire        cpu_gpio_irq_en,
  output wire        irq,
  // Pins
  input  wire [31:0] gpio_in,
  output wire [31:0] gpio_out,
  output wire [31:0] gpio_oe,
  // External memory data lines
  input  wire [15:0] memctl_out,
  input  wire [15:0] memctl_oe,
  input  wire [15:0] mem_data_in,
  output reg  [15:0] mem_data_out,
  output reg  [15:0] mem_data_oe,
  // Peripherals
  input  wire        usb_tx_enable,
  input  wire [3:0]  fast_serial_out,
  input  wire [3:0]  fast_serial_oe,
  output reg  [3:0]  fast_serial_in,
  input  wire [3:0]  spi_out,
  input  wire [3:0]  spi_oe,
  output reg  [3:0]  spi_pin_in,
  input  wire [21:0] mode_pin_out,
  input  wire [21:0] mode_pin_oe,
  output wire [21:0] mode_pin_in,
  output wire        drive_if_sel,
  output wire        host_port_interface_sel,
  output wire        scan_test_sel
);

  // ============================================================
  // Register state
  reg [15:0] ctl_ff;
  reg [15:0] out_low_ff;
  reg [15:0] out_high_ff;
  reg [15:0] dir_low_ff;
  reg [15:0] dir_high_ff;
  reg [31:0] in_ff;
  reg [1:0]  status_ff;
  reg [1:0]  mask_ff;

  // Bus state
  reg        aw_held_ff;
  reg [19:0] aw_addr_ff;
  reg        w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;
  reg        rvalid_ff;
  reg [1:0]  rresp_ff;
  reg [31:0] rdata_ff;

  // ============================================================
  // Address decode: index in bits 17:2, everything else must be zero
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_CTL  = 4'h1;
  localparam [3:0] SEL_OL   = 4'h2;
  localparam [3:0] SEL_IL   = 4'h3;
  localparam [3:0] SEL_DL   = 4'h4;
  localparam [3:0] SEL_OH   = 4'h5;
  localparam [3:0] SEL_IH   = 4'h6;
  localparam [3:0] SEL_DH   = 4'h7;
  localparam [3:0] SEL_IST  = 4'h8;
  localparam [3:0] SEL_IMK  = 4'h9;

  function [3:0] decode;
    input [19:0] addr;
    begin
      decode = SEL_NONE;
      if (addr[19:18] == 2'h0 && addr[1:0] == 2'h0) begin
        case (addr[17:2])
          `IDX_CONTROL:    decode = SEL_CTL;
          `IDX_OUT_LOW:    decode = SEL_OL;
          `IDX_IN_LOW:     decode = SEL_IL;
          `IDX_DIR_LOW:    decode = SEL_DL;
          `IDX_OUT_HIGH:   decode = SEL_OH;
          `IDX_IN_HIGH:    decode = SEL_IH;
          `IDX_DIR_HIGH:   decode = SEL_DH;
          `IDX_IRQ_STATUS: decode = SEL_IST;
          `IDX_IRQ_MASK:   decode = SEL_IMK;
          default:         decode = SEL_NONE;
        endcase
      end
    end
  endfunction

  // ============================================================
  // Write channel: address and data taken in either order
  wire       aw_hs   = s_axi_awvalid & ~aw_held_ff & ~bvalid_ff;
  wire       w_hs    = s_axi_wvalid & ~w_held_ff & ~bvalid_ff;
  wire       have_aw = aw_held_ff | aw_hs;
  wire       have_w  = w_held_ff | w_hs;
  wire       do_wr   = have_aw & have_w & ~bvalid_ff;
  wire [19:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  wire [3:0]  wr_sel  = decode(wr_addr);

  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // Per byte lane write enables
  wire we_lo = do_wr & wr_strb[0];
  wire we_hi = do_wr & wr_strb[1];

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 20'h00000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RESP_OKAY;
    end else begin
      if (aw_hs && !do_wr) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs && !do_wr) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // Configuration registers
  // Write protect only guards the upper byte; it can only be left by reset
  wire ctl_upper_ok = ~ctl_ff[`CTL_WRITE_PROTECT];
  wire [15:0] ctl_wmask = `CTL_WRITABLE;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff      <= `CTL_RESET;
      out_low_ff  <= `PIN_REG_RESET;
      out_high_ff <= `PIN_REG_RESET;
      dir_low_ff  <= `PIN_REG_RESET;
      dir_high_ff <= `PIN_REG_RESET;
      mask_ff     <= 2'h0;
    end else begin
      if (wr_sel == SEL_CTL) begin
        if (we_lo) begin
          ctl_ff[7:0] <= wr_data[7:0] & ctl_wmask[7:0];
        end
        if (we_hi && ctl_upper_ok) begin
          // Reserved bits 13:12 are dropped; software should write zero
          ctl_ff[15:8] <= wr_data[15:8] & ctl_wmask[15:8];
        end
      end
      if (wr_sel == SEL_OL && we_lo) out_low_ff[7:0]   <= wr_data[7:0];
      if (wr_sel == SEL_OL && we_hi) out_low_ff[15:8]  <= wr_data[15:8];
      if (wr_sel == SEL_OH && we_lo) out_high_ff[7:0]  <= wr_data[7:0];
      if (wr_sel == SEL_OH && we_hi) out_high_ff[15:8] <= wr_data[15:8];
      if (wr_sel == SEL_DL && we_lo) dir_low_ff[7:0]   <= wr_data[7:0];
      if (wr_sel == SEL_DL && we_hi) dir_low_ff[15:8]  <= wr_data[15:8];
      if (wr_sel == SEL_DH && we_lo) dir_high_ff[7:0]  <= wr_data[7:0];
      if (wr_sel == SEL_DH && we_hi) dir_high_ff[15:8] <= wr_data[15:8];
      if (wr_sel == SEL_IMK && we_lo) mask_ff <= wr_data[1:0];
    end
  end

  // ============================================================
  // Pin sampling, one flop; inputs are already synchronous
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_ff <= 32'h00000000;
    end else begin
      in_ff <= gpio_in;
    end
  end

  // ============================================================
  // Pin interrupts
  wire [1:0] irq_event;
  wire [1:0] irq_level = {in_ff[`IRQ_PIN_ONE], in_ff[`IRQ_PIN_ZERO]};
  wire [1:0] irq_rise  = {ctl_ff[`CTL_PIN_INTERRUPT_ONE_RISE], ctl_ff[`CTL_PIN_INTERRUPT_ZERO_RISE]};
  wire [1:0] irq_en    = {ctl_ff[`CTL_PIN_INTERRUPT_ONE_EN], ctl_ff[`CTL_PIN_INTERRUPT_ZERO_EN]};

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_irq
      pin_edge_detect u_edge (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .level       (irq_level[k]),
        .rise_sel    (irq_rise[k]),
        .enable      (irq_en[k]),
        .event_pulse (irq_event[k])
      );
    end
  endgenerate

  // ============================================================
  // Read channel: one cycle latency, status cleared by its read
  wire       ar_hs  = s_axi_arvalid & ~rvalid_ff;
  wire [3:0] rd_sel = decode(s_axi_araddr);
  wire       st_clr = ar_hs & (rd_sel == SEL_IST);

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Sticky status: a new event beats a clearing read in the same cycle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= 2'h0;
    end else begin
      status_ff <= (status_ff & {2{~st_clr}}) | irq_event;
    end
  end

  // Software mask, then the processor GPIO enable gates the line
  assign irq = cpu_gpio_irq_en & |(status_ff & mask_ff);

  reg [15:0] nxt_rdata;

  // Read mux
  always @* begin
    case (rd_sel)
      SEL_CTL: nxt_rdata = ctl_ff;
      SEL_OL:  nxt_rdata = out_low_ff;
      SEL_IL:  nxt_rdata = in_ff[15:0];
      SEL_DL:  nxt_rdata = dir_low_ff;
      SEL_OH:  nxt_rdata = out_high_ff;
      SEL_IH:  nxt_rdata = in_ff[31:16];
      SEL_DH:  nxt_rdata = dir_high_ff;
      SEL_IST: nxt_rdata = {14'h0, status_ff};
      SEL_IMK: nxt_rdata = {14'h0, mask_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `RESP_OKAY;
      rdata_ff  <= 32'h00000000;
    end else begin
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        rdata_ff  <= {16'h0000, nxt_rdata};
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // Routing decode
  wire [2:0] mode      = ctl_ff[`CTL_MODE_HI:`CTL_MODE_LO];
  wire       fast_mem  = ctl_ff[`CTL_FAST_MEM];
  wire       fast_gpio = ctl_ff[`CTL_FAST_EN] & ~fast_mem;
  wire       spi_mem   = ctl_ff[`CTL_SPI_MEM];
  wire       spi_gpio  = ctl_ff[`CTL_SPI_EN] & ~spi_mem;
  wire       ss_move   = spi_gpio & ctl_ff[`CTL_SS_REROUTE];
  wire       tx_export = ctl_ff[`CTL_TX_EXPORT];

  // Reserved codes leave the pins as plain GPIO
  assign drive_if_sel            = (mode == `MODE_DRIVE_IF);
  assign host_port_interface_sel = (mode == `MODE_HOST_PORT);
  assign scan_test_sel           = (mode == `MODE_SCAN);
  wire   mode_active = drive_if_sel | host_port_interface_sel | scan_test_sel;

  // Mode group pins feed the selected function straight from the pins
  assign mode_pin_in = {gpio_in[24:19], gpio_in[15:0]};

  reg [31:0] fn_claim;
  reg [31:0] fn_out;
  reg [31:0] fn_oe;

  // Later assignments win: serial routes sit above the mode group
  always @* begin
    fn_claim = 32'h00000000;
    fn_out   = 32'h00000000;
    fn_oe    = 32'h00000000;
    if (mode_active) begin
      fn_claim[15:0]  = 16'hffff;
      fn_out[15:0]    = mode_pin_out[15:0];
      fn_oe[15:0]     = mode_pin_oe[15:0];
      fn_claim[24:19] = 6'h3f;
      fn_out[24:19]   = mode_pin_out[21:16];
      fn_oe[24:19]    = mode_pin_oe[21:16];
    end
    if (spi_gpio) begin
      fn_claim[8]  = 1'b1;
      fn_out[8]    = spi_out[0];
      fn_oe[8]     = spi_oe[0];
      fn_claim[11:10] = 2'h3;
      fn_out[11:10]   = spi_out[3:2];
      fn_oe[11:10]    = spi_oe[3:2];
      if (ss_move) begin
        fn_claim[`SS_ALT_PIN] = 1'b1;
        fn_out[`SS_ALT_PIN]   = spi_out[1];
        fn_oe[`SS_ALT_PIN]    = spi_oe[1];
      end else begin
        fn_claim[9] = 1'b1;
        fn_out[9]   = spi_out[1];
        fn_oe[9]    = spi_oe[1];
      end
    end
    if (fast_gpio) begin
      fn_claim[18:16] = 3'h7;
      fn_out[18:16]   = fast_serial_out[2:0];
      fn_oe[18:16]    = fast_serial_oe[2:0];
      fn_claim[26]    = 1'b1;
      fn_out[26]      = fast_serial_out[3];
      fn_oe[26]       = fast_serial_oe[3];
    end
    if (tx_export) begin
      fn_claim[`TX_EXPORT_PIN] = 1'b1;
      fn_out[`TX_EXPORT_PIN]   = usb_tx_enable;
      fn_oe[`TX_EXPORT_PIN]    = 1'b1;
    end
  end

  // ============================================================
  // Per pin output selection
  wire [31:0] gpio_data = {out_high_ff, out_low_ff};
  wire [31:0] gpio_dir  = {dir_high_ff, dir_low_ff};

  genvar p;
  generate
    for (p = 0; p < 32; p = p + 1) begin : g_pin
      pin_cell u_cell (
        .gpio_data (gpio_data[p]),
        .gpio_dir  (gpio_dir[p]),
        .fn_claim  (fn_claim[p]),
        .fn_out    (fn_out[p]),
        .fn_oe     (fn_oe[p]),
        .pin_out   (gpio_out[p]),
        .pin_oe    (gpio_oe[p])
      );
    end
  endgenerate

  // ============================================================
  // Memory data lines and serial inputs
  always @* begin
    mem_data_out = memctl_out;
    mem_data_oe  = memctl_oe;
    if (spi_mem) begin
      mem_data_out[11:8] = spi_out;
      mem_data_oe[11:8]  = spi_oe;
    end
    if (fast_mem) begin
      mem_data_out[15:12] = fast_serial_out;
      mem_data_oe[15:12]  = fast_serial_oe;
    end
  end

  // Idle serial inputs read high so a disconnected select stays inactive
  always @* begin
    spi_pin_in = 4'hf;
    if (spi_mem) begin
      spi_pin_in = mem_data_in[11:8];
    end else if (spi_gpio) begin
      spi_pin_in = gpio_in[11:8];
      if (ss_move) begin
        spi_pin_in[1] = gpio_in[`SS_ALT_PIN];
      end
    end
    fast_serial_in = 4'hf;
    if (fast_mem) begin
      fast_serial_in = mem_data_in[15:12];
    end else if (fast_gpio) begin
      fast_serial_in = {gpio_in[26], gpio_in[18:16]};
    end
  end

endmodule

// [tb/gpio_port_asserts.sv]
// Port-level concurrent checks for the pin routing and GPIO block
module gpio_port_asserts (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_gpio_irq_en,
  input wire logic        irq,
  input wire logic [31:0] gpio_in,
  input wire logic [31:0] gpio_oe,
  input wire logic [21:0] mode_pin_in,
  input wire logic        drive_if_sel,
  input wire logic        host_port_interface_sel,
  input wire logic        scan_test_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ============================================================
  // Bus handshake steps
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ============================================================
  // Register bus answers
  a_write_answer: assert property (s_write_taken |=> s_axi_bvalid && !s_axi_awready
    && !s_axi_wready) else $error("write not answered next cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck after handshake");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // ============================================================
  // Pins, mode decode and interrupt gate
  a_irq_gate: assert property (!cpu_gpio_irq_en |-> !irq)
    else $error("interrupt with processor enable low");
  a_mode_inputs: assert property (mode_pin_in == {gpio_in[24:19], gpio_in[15:0]})
    else $error("mode group inputs misrouted");
  a_mode_onehot: assert property ($onehot0({drive_if_sel, host_port_interface_sel,
    scan_test_sel})) else $error("several pin functions selected");
  a_reset_inputs: assert property ($rose(arst_n) |-> gpio_oe == 32'h0)
    else $error("pin driven after reset");
endmodule

bind gpio_port gpio_port_asserts chk (
  .ref_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_gpio_irq_en, .irq,
  .gpio_in, .gpio_oe, .mode_pin_in, .drive_if_sel, .host_port_interface_sel, .scan_test_sel
);

// [tb/pin_world.sv]
// Behavioural model of the devices wired to the pins and memory lines
module pin_world (
  input  wire logic [31:0] gpio_out,
  input  wire logic [31:0] gpio_oe,
  input  wire logic [31:0] ext_level,
  input  wire logic [31:0] ext_drive,
  input  wire logic [15:0] mem_data_out,
  input  wire logic [15:0] mem_data_oe,
  output wire logic [31:0] gpio_in,
  output wire logic [15:0] mem_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven lines fall to the board pull-down, never keep a stale level
  assign gpio_in     = (gpio_oe & gpio_out) | (~gpio_oe & ext_drive & ext_level);
  assign mem_data_in = mem_data_oe & mem_data_out;
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the pin routing and GPIO block
`include "gpio_port_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, arst_n = 1'b0, usb_tx_enable = 1'b0, cpu_gpio_irq_en = 1'b0;
  logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, gpio_in, gpio_out, gpio_oe, ext_level = '0, ext_drive = '0;
  logic [15:0] memctl_out = '0, memctl_oe = '0, mem_data_in, mem_data_out, mem_data_oe;
  logic [3:0]  fast_serial_out = '0, fast_serial_oe = '0, fast_serial_in;
  logic [3:0]  spi_out = '0, spi_oe = '0, spi_pin_in;
  logic [21:0] mode_pin_out = '0, mode_pin_oe = '0, mode_pin_in;
  logic        drive_if_sel, host_port_interface_sel, scan_test_sel;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [31:0] d, dir;
  logic [2:0]  exp3;
  logic [15:0] idx_tab[8] = '{`IDX_CONTROL, `IDX_OUT_LOW, `IDX_IN_LOW, `IDX_DIR_LOW,
                              `IDX_OUT_HIGH, `IDX_IN_HIGH, `IDX_DIR_HIGH, `IDX_IRQ_MASK};
  int          fail_count = 0, samples_checked = 0, seed = 81027;

  gpio_port dut (
    .ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_gpio_irq_en, .irq, .gpio_in, .gpio_out, .gpio_oe,
    .memctl_out, .memctl_oe, .mem_data_in, .mem_data_out, .mem_data_oe, .usb_tx_enable,
    .fast_serial_out, .fast_serial_oe, .fast_serial_in, .spi_out, .spi_oe, .spi_pin_in,
    .mode_pin_out, .mode_pin_oe, .mode_pin_in, .drive_if_sel, .host_port_interface_sel,
    .scan_test_sel
  );
  pin_world board (
    .gpio_out, .gpio_oe, .ext_level, .ext_drive, .mem_data_out, .mem_data_oe, .gpio_in,
    .mem_data_in
  );

  always #5 ref_clk = ~ref_clk;

  // ============================================================
  // Comparison, bus master and closing tasks
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data offered together; each dropped once taken
  task automatic axi_write(input logic [15:0] idx, input logic [15:0] v,
                           input logic [1:0] er = `RESP_OKAY);
    wr_q.push_back(er);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask

  task automatic axi_read(input logic [15:0] idx, input logic [33:0] exp);
    rd_q.push_back(exp);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask

  task automatic complete_run;
    fail_count += rd_q.size() + wr_q.size();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Answers are matched in arrival order with the notes left by the master
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
  end

  // Hang guard, far beyond the under two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    memctl_out <= $random(seed);
    memctl_oe <= 16'hffff;
    mode_pin_out <= $random(seed);
    mode_pin_oe <= $random(seed);
    @(posedge ref_clk);
    foreach (idx_tab[i]) axi_read(idx_tab[i], 34'h0);
    axi_write(16'h0100, 16'h1234, `RESP_SLVERR);
    axi_read(16'h0100, {`RESP_SLVERR, 32'h0});
    // Random outputs, directions and far-side levels
    repeat (3) begin
      d = $random(seed);
      dir = $random(seed);
      ext_level <= $random(seed);
      ext_drive <= ~dir;
      axi_write(`IDX_OUT_LOW, d[15:0]);
      axi_write(`IDX_OUT_HIGH, d[31:16]);
      axi_write(`IDX_DIR_LOW, dir[15:0]);
      axi_write(`IDX_DIR_HIGH, dir[31:16]);
      repeat (2) @(posedge ref_clk);
      check("oe", gpio_oe, dir);
      check("out", gpio_out & dir, d & dir);
      axi_read(`IDX_OUT_LOW, {18'h0, d[15:0]});
      axi_read(`IDX_OUT_HIGH, {18'h0, d[31:16]});
      d = (d & dir) | (ext_level & ~dir);
      axi_read(`IDX_IN_LOW, {18'h0, d[15:0]});
      axi_read(`IDX_IN_HIGH, {18'h0, d[31:16]});
    end
    // Peripheral routing over pins left in random GPIO state
    fast_serial_out <= $random(seed);
    fast_serial_oe <= 4'hf;
    spi_out <= $random(seed);
    spi_oe <= 4'hd;
    ext_drive <= ~dir | 32'h0000_8000;
    axi_write(`IDX_CONTROL, 16'h0080);
    check("fs_pin", {gpio_out[26], gpio_out[18:16], gpio_oe[26], gpio_oe[18:16]},
          {fast_serial_out, 4'hf});
    check("fs_in", fast_serial_in, fast_serial_out);
    axi_write(`IDX_CONTROL, 16'h00c0);
    check("fs_mem", {mem_data_out[15:12], mem_data_oe[15:12], fast_serial_in},
          {fast_serial_out, 4'hf, fast_serial_out});
    check("fs_free", gpio_oe[26], dir[26]);
    axi_write(`IDX_CONTROL, 16'h0020);
    check("spi_pin", gpio_out[11:8] & 4'hd, spi_out & 4'hd);
    axi_write(`IDX_CONTROL, 16'h0820);
    check("ss_alt", spi_pin_in[1], ext_level[15]);
    axi_write(`IDX_CONTROL, 16'h0830);
    check("spi_mem", {mem_data_out[11:8] & 4'hd, spi_pin_in}, {2{spi_out & 4'hd}});
    check("mem_back", mem_data_out[15:12], memctl_out[15:12]);
    for (int t = 0; t < 2; t++) begin
      usb_tx_enable <= t[0];
      axi_write(`IDX_CONTROL, 16'h4000);
      check("tx_pin", {gpio_out[30], gpio_oe[30]}, {t[0], 1'b1});
    end
    // Every pin function code
    for (int m = 0; m < 8; m++) begin
      axi_write(`IDX_CONTROL, {5'h00, m[2:0], 8'h00});
      exp3 = (m == 4) ? 3'b100 : (m == 5) ? 3'b010 : (m == 6) ? 3'b001 : 3'b000;
      check("mode_sel", {drive_if_sel, host_port_interface_sel, scan_test_sel}, exp3);
      check("mode_oe", gpio_oe[15:0], (exp3 != 0) ? mode_pin_oe[15:0] : dir[15:0]);
      check("tx_off", gpio_oe[30], dir[30]);
    end
    // Pin interrupts: edge choice, masking and processor gate
    ext_level <= 32'h0;
    ext_drive <= 32'hffff_ffff;
    axi_write(`IDX_DIR_HIGH, 16'h0000);
    axi_write(`IDX_IRQ_MASK, 16'h0002);
    cpu_gpio_irq_en <= 1'b1;
    axi_write(`IDX_CONTROL, 16'h0003);
    ext_level[24] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("irq_masked", irq, 1'b0);
    axi_read(`IDX_IRQ_STATUS, 34'h1);
    ext_level[24] <= 1'b0;
    axi_write(`IDX_IRQ_MASK, 16'h0003);
    axi_write(`IDX_CONTROL, 16'h0004);
    ext_level[25] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("irq_rise", irq, 1'b0);
    ext_level[25] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("irq_fall", irq, 1'b1);
    cpu_gpio_irq_en <= 1'b0;
    @(posedge ref_clk);
    check("irq_gate", irq, 1'b0);
    axi_read(`IDX_IRQ_STATUS, 34'h2);
    // Write protect holds the upper byte until a reset
    axi_write(`IDX_CONTROL, 16'h8500);
    axi_write(`IDX_CONTROL, 16'h0001);
    axi_read(`IDX_CONTROL, 34'h8501);
    check("wp_mode", host_port_interface_sel, 1'b1);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    axi_read(`IDX_CONTROL, 34'h0);
    axi_read(`IDX_DIR_LOW, 34'h0);
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
endmodule
